// ---- vwm_top.sv ----
// VRAM window mapper: maps host windows onto a 512 KB video RAM.
// Assumes host requests are one byte per cycle, synchronous to clk.
//
// Overview of operation
// - Each window byte costs one video RAM cycle
// - Assert external memory select on VRAM hits
// - Window A 2000-3FFF, window B 4000-7FFF
// - Each window enabled per CPU and display
// - Separate bank numbers per master per window
// - Window A: sixty-four 8 KB banks
// - Window B: thirty-two 16 KB banks
// - Emulated expansion off while window B enabled
// - Expansion lives in upper half of VRAM
// - CPU A control: bit7 map, bits5:0 bank
// - Display A control: bit7 map, bits5:0 bank
// - CPU B control: bit7 map, bits4:0 bank
// - Display B control: bit7 maps window B
// - Video RAM addresses are 19 bits
// - A address is bank over A[12:0]
// - B address is bank over A[13:0]
`timescale 1ns/100ps

module vwm_top
  import vwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host side
  input  wire logic        host_req,
  input  wire logic        host_is_display,
  input  wire logic        host_we,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic             external_memory_select,
  output logic             host_rvalid,
  output logic [7:0]       host_rdata,
  // Video RAM port
  output logic             vram_en,
  output logic             vram_we,
  output logic [18:0]      vram_addr,
  output logic [7:0]       vram_wdata,
  input  wire logic [7:0]  vram_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  a_cpu_ff;
  logic [7:0]  a_disp_ff;
  logic [7:0]  b_cpu_ff;
  logic [7:0]  b_disp_ff;
  logic [7:0]  emu_ff;
  logic [15:0] hit_cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [4:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        awready_ff;
  logic        wready_ff;

  wire aw_take  = s_axi_awvalid && awready_ff;
  wire w_take   = s_axi_wvalid && wready_ff;
  wire wr_go    = aw_held_ff && w_held_ff && !bvalid_ff;
  wire wr_a_c   = wr_go && awaddr_ff == {1'b0, VWM_OFS_A_CPU};
  wire wr_a_d   = wr_go && awaddr_ff == {1'b0, VWM_OFS_A_DISP};
  wire wr_b_c   = wr_go && awaddr_ff == {1'b0, VWM_OFS_B_CPU};
  wire wr_b_d   = wr_go && awaddr_ff == {1'b0, VWM_OFS_B_DISP};
  wire wr_emu   = wr_go && awaddr_ff == VWM_OFS_EMUCTL;
  wire wr_stat  = wr_go && awaddr_ff == VWM_OFS_STATUS;
  wire wr_ok    = wr_a_c || wr_a_d || wr_b_c || wr_b_d || wr_emu || wr_stat;
  wire wr_lane0 = wstrb_ff[0];
  wire [7:0] wbyte = wdata_ff[7:0];

  // Write address channel, held until the write is carried out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 5'h00;
      awready_ff <= 1'b0;
    end else begin
      awready_ff <= !aw_held_ff && !aw_take && !wr_go;

      if (wr_go) begin
        aw_held_ff <= 1'b0;
      end else if (aw_take) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
    end
  end

  // Write data channel, held until the write is carried out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      wready_ff <= 1'b0;
    end else begin
      wready_ff <= !w_held_ff && !w_take && !wr_go;

      if (wr_go) begin
        w_held_ff <= 1'b0;
      end else if (w_take) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
    end
  end

  // Write response, stands until the master takes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= VWM_RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? VWM_RESP_OKAY : VWM_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, reserved bits held at zero except bit 4 of emulation control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      a_cpu_ff  <= VWM_CTL_RST;
      a_disp_ff <= VWM_CTL_RST;
      b_cpu_ff  <= VWM_CTL_RST;
      b_disp_ff <= VWM_CTL_RST;
      emu_ff    <= VWM_EMU_RST;
    end else begin
      if (wr_a_c && wr_lane0) a_cpu_ff  <= wbyte & VWM_A_MASK;
      if (wr_a_d && wr_lane0) a_disp_ff <= wbyte & VWM_A_MASK;
      if (wr_b_c && wr_lane0) b_cpu_ff  <= wbyte & VWM_B_MASK;
      if (wr_b_d && wr_lane0) b_disp_ff <= wbyte & VWM_B_MASK;
      if (wr_emu && wr_lane0) emu_ff    <= wbyte & VWM_EMU_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  wire ar_take = s_axi_arvalid && arready_ff;
  wire [4:0] ra = s_axi_araddr;
  wire rd_hit  = ra == {1'b0, VWM_OFS_A_CPU} || ra == {1'b0, VWM_OFS_A_DISP}
              || ra == {1'b0, VWM_OFS_B_CPU} || ra == {1'b0, VWM_OFS_B_DISP}
              || ra == VWM_OFS_EMUCTL || ra == VWM_OFS_STATUS;
  wire [31:0] rd_word =
      ra == {1'b0, VWM_OFS_A_CPU}  ? {24'h000000, a_cpu_ff}  :
      ra == {1'b0, VWM_OFS_A_DISP} ? {24'h000000, a_disp_ff} :
      ra == {1'b0, VWM_OFS_B_CPU}  ? {24'h000000, b_cpu_ff}  :
      ra == {1'b0, VWM_OFS_B_DISP} ? {24'h000000, b_disp_ff} :
      ra == VWM_OFS_EMUCTL         ? {24'h000000, emu_ff}    :
      ra == VWM_OFS_STATUS         ? {16'h0000, hit_cnt_ff}  :
                                     32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= VWM_RESP_OKAY;
    end else begin
      arready_ff <= !rvalid_ff && !ar_take;
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_word;
        rresp_ff  <= rd_hit ? VWM_RESP_OKAY : VWM_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window decode and address forming
  wire in_a = host_addr[15:13] == VWM_WIN_A_TOP;
  wire in_b = host_addr[15:14] == VWM_WIN_B_TOP;

  // Per-master control selection
  wire [7:0] ctl_a = host_is_display ? a_disp_ff : a_cpu_ff;
  wire [7:0] ctl_b = host_is_display ? b_disp_ff : b_cpu_ff;
  wire en_a = ctl_a[VWM_EN_BIT];
  wire en_b = ctl_b[VWM_EN_BIT];
  wire b_any = b_cpu_ff[VWM_EN_BIT] || b_disp_ff[VWM_EN_BIT];

  // Emulation is shared by both masters, off while window B is on
  wire emu_on = emu_ff[VWM_EN_BIT] && !b_any;

  vwm_src_t src;
  assign src = (in_a && en_a)   ? VWM_SRC_A   :
               (in_b && en_b)   ? VWM_SRC_B   :
               (in_b && emu_on) ? VWM_SRC_EMU :
                                  VWM_SRC_NONE;

  logic [18:0] addr_mux;
  always_comb begin
    unique case (src)
      VWM_SRC_A:    addr_mux = {ctl_a[5:0], host_addr[12:0]};
      VWM_SRC_B:    addr_mux = {ctl_b[4:0], host_addr[13:0]};
      VWM_SRC_EMU:  addr_mux = {1'b1, emu_ff[VWM_EMU_BANK_W-1:0],
                                host_addr[13:0]};
      VWM_SRC_NONE: addr_mux = 19'h00000;
    endcase
  end

  wire hit = host_req && src != VWM_SRC_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // Video RAM access, one cycle per byte
  logic        vram_en_ff;
  logic        vram_we_ff;
  logic [18:0] vram_addr_ff;
  logic [7:0]  vram_wdata_ff;
  logic        ext_sel_ff;
  logic        rd_pend_ff;
  logic        host_rvalid_ff;
  logic [7:0]  host_rdata_ff;

  // Direction of the hit
  wire wr_hit = hit && host_we;
  wire rd_hit_host = hit && !host_we;

  // Next hit count
  wire [15:0] nxt_hit_cnt = hit_cnt_ff + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // Memory strobe and direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vram_en_ff <= 1'b0;
      vram_we_ff <= 1'b0;
    end else begin
      vram_en_ff <= hit;
      vram_we_ff <= wr_hit;
    end
  end

  // Memory address and write data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vram_addr_ff  <= 19'h00000;
      vram_wdata_ff <= 8'h00;
    end else begin
      vram_addr_ff  <= addr_mux;
      vram_wdata_ff <= host_wdata;
    end
  end

  // Host memory disable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_sel_ff <= 1'b0;
    end else begin
      ext_sel_ff <= hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read return to the host
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend_ff     <= 1'b0;
      host_rvalid_ff <= 1'b0;
    end else begin
      rd_pend_ff     <= rd_hit_host;
      host_rvalid_ff <= rd_pend_ff;
    end
  end

  // Read byte capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_rdata_ff <= 8'h00;
    end else begin
      if (rd_pend_ff) begin
        host_rdata_ff <= vram_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count of window hits for the status register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hit_cnt_ff <= 16'h0000;
    end else begin
      if (hit) begin
        hit_cnt_ff <= nxt_hit_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_awready          = awready_ff;
  assign s_axi_wready           = wready_ff;
  assign s_axi_bvalid           = bvalid_ff;
  assign s_axi_bresp            = bresp_ff;
  assign s_axi_arready          = arready_ff;
  assign s_axi_rvalid           = rvalid_ff;
  assign s_axi_rdata            = rdata_ff;
  assign s_axi_rresp            = rresp_ff;
  assign external_memory_select = ext_sel_ff;
  assign host_rvalid            = host_rvalid_ff;
  assign host_rdata             = host_rdata_ff;
  assign vram_en                = vram_en_ff;
  assign vram_we                = vram_we_ff;
  assign vram_addr              = vram_addr_ff;
  assign vram_wdata             = vram_wdata_ff;

endmodule : vwm_top

// ---- vwm_pkg.sv ----
// Package for the VRAM window mapper: register map, field layout, windows.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit host address bus.
package vwm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [3:0] VWM_OFS_A_CPU   = 4'h0;
  localparam logic [3:0] VWM_OFS_A_DISP  = 4'h4;
  localparam logic [3:0] VWM_OFS_B_CPU   = 4'h8;
  localparam logic [3:0] VWM_OFS_B_DISP  = 4'hc;
  localparam logic [3:0] VWM_OFS_EMU     = 4'h0;  // Index base of emulation
  localparam logic [4:0] VWM_OFS_EMUCTL  = 5'h10;
  localparam logic [4:0] VWM_OFS_STATUS  = 5'h14;

  //////////////////////////////////////////////////////////////////////////
  // Field layout and reset values
  localparam int         VWM_EN_BIT      = 7;
  localparam logic [7:0] VWM_A_MASK      = 8'hbf;
  localparam logic [7:0] VWM_B_MASK      = 8'h9f;
  localparam logic [7:0] VWM_CTL_RST     = 8'h00;
  localparam logic [7:0] VWM_EMU_MASK    = 8'h9f;
  localparam logic [7:0] VWM_EMU_RST     = 8'h00;
  localparam int         VWM_EMU_BANK_W  = 4;

  //////////////////////////////////////////////////////////////////////////
  // Host windows
  localparam logic [2:0] VWM_WIN_A_TOP   = 3'h1;  // Address bits 15:13
  localparam logic [1:0] VWM_WIN_B_TOP   = 2'h1;  // Address bits 15:14
  localparam int         VWM_VADDR_W     = 19;

  //////////////////////////////////////////////////////////////////////////
  // Bus answers
  localparam logic [1:0] VWM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VWM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {VWM_SRC_NONE, VWM_SRC_A, VWM_SRC_B, VWM_SRC_EMU}
    vwm_src_t;

endpackage : vwm_pkg

// ---- vwm_vram_model.sv ----
// Video RAM model for the VRAM window mapper's memory port.
// Assumes a combinational read that stays valid one cycle after enable.
`timescale 1ns/100ps
module vwm_vram_model (
  input  wire logic        clk,
  input  wire logic        vram_en,
  input  wire logic        vram_we,
  input  wire logic [18:0] vram_addr,
  input  wire logic [7:0]  vram_wdata,
  output logic [7:0]       vram_rdata
);
  logic [7:0]  mem [0:524287];
  logic [18:0] addr_ff;
  logic        en_ff;
  //////////////////////////////////////////////////////////////////////////
  // Byte store, one byte per enabled write cycle
  always_ff @(posedge clk) begin
    en_ff <= vram_en;
    if (vram_en) addr_ff <= vram_addr;
    if (vram_en && vram_we) mem[vram_addr] <= vram_wdata;
  end
  // Released data line shows the inverse of the held byte
  assign vram_rdata = vram_en ? mem[vram_addr] :
                      en_ff ? mem[addr_ff] : ~mem[addr_ff];
endmodule : vwm_vram_model

// ---- vwm_monitor.sv ----
// Checker for the VRAM window mapper host and video RAM ports.
// Assumes it is bound to vwm_top and sees only its ports.
`timescale 1ns/100ps
module vwm_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        host_req,
  input wire logic        host_we,
  input wire logic [15:0] host_addr,
  input wire logic [7:0]  host_wdata,
  input wire logic        external_memory_select,
  input wire logic        host_rvalid,
  input wire logic [7:0]  host_rdata,
  input wire logic        vram_en,
  input wire logic        vram_we,
  input wire logic [18:0] vram_addr,
  input wire logic [7:0]  vram_wdata,
  input wire logic [7:0]  vram_rdata
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_hit;
    host_req && !host_we ##1 vram_en;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_sel_on_hit: assert property (vram_en |-> external_memory_select)
    else $error("select missing on hit");
  a_hit_cause: assert property (vram_en |-> $past(host_req))
    else $error("vram cycle without request");
  a_dir_pass: assert property (vram_en |-> vram_we == $past(host_we))
    else $error("vram direction wrong");
  a_wdata_pass: assert property (
    vram_en && vram_we |-> vram_wdata == $past(host_wdata))
    else $error("vram write data wrong");
  a_win_a_addr: assert property (
    vram_en && $past(host_addr[15:13]) == 3'h1
    |-> vram_addr[12:0] == $past(host_addr[12:0]))
    else $error("window a offset wrong");
  a_win_b_addr: assert property (
    vram_en && $past(host_addr[15:14]) == 2'h1
    |-> vram_addr[13:0] == $past(host_addr[13:0]))
    else $error("window b offset wrong");
  a_no_outside: assert property (
    host_req && (host_addr[15:13] == 3'h0 || host_addr[15])
    |=> !vram_en && !external_memory_select)
    else $error("hit outside windows");
  a_read_back: assert property (
    s_rd_hit |=> host_rvalid && host_rdata == $past(vram_rdata))
    else $error("read data not returned");
endmodule : vwm_monitor
bind vwm_top vwm_monitor vwm_monitor_inst (.*);

// ---- tb_top.sv ----
// Testbench for the VRAM window mapper: register and window tests.
// Assumes the video RAM model on the memory port.
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  bad_count++; $display("wrong value at %0t: %h, %h", $time, a, b); \
  end end
module tb_top
  import vwm_pkg::*;
;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, host_req;
  logic        host_is_display, host_we, external_memory_select;
  logic        host_rvalid, vram_en, vram_we;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] host_addr;
  logic [7:0]  host_wdata, host_rdata, vram_wdata, vram_rdata;
  logic [18:0] vram_addr;
  int          bad_count, comparisons;
  vwm_top vwm_top_inst (.*);
  vwm_vram_model vwm_vram_model_inst (.*);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task axi_wr(input logic [4:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 0;
    `CHK(s_axi_bresp, VWM_RESP_OKAY)
  endtask : axi_wr
  task axi_rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge clk);
    s_axi_rready <= 0;
    `CHK(s_axi_rresp, r)
    `CHK(s_axi_rdata[7:0], d)
  endtask : axi_rd
  task host_acc(input logic dsp, input logic we, input logic [15:0] a,
                input logic [7:0] d, input logic hit, input logic [18:0] va);
    @(posedge clk);
    {host_req, host_is_display, host_we} <= {1'b1, dsp, we};
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_req <= 0;
    #1;
    `CHK(external_memory_select, hit)
    `CHK(vram_en, hit)
    if (hit) `CHK(vram_addr, va)
    @(posedge clk);
    #1;
    `CHK(host_rvalid, hit && !we)
    if (hit && !we) `CHK(host_rdata, d)
  endtask : host_acc
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, host_req, host_is_display, host_we} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, host_addr, host_wdata} = '0;
    s_axi_wstrb = 4'h1;
    rst_n = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 16; i += 4) axi_rd(i[4:0], 8'h00, 2'h0);
    axi_rd(5'h18, 8'h00, VWM_RESP_SLVERR);
    axi_wr(5'h00, 8'hc9);
    axi_rd(5'h00, 8'h89, VWM_RESP_OKAY);
    axi_wr(5'h04, 8'h85);
    axi_rd(5'h04, 8'h85, VWM_RESP_OKAY);
    axi_wr(5'h08, 8'hff);
    axi_rd(5'h08, 8'h9f, VWM_RESP_OKAY);
    axi_wr(5'h08, 8'h84);
    axi_wr(5'h0c, 8'hff);
    axi_rd(5'h0c, 8'h9f, VWM_RESP_OKAY);
    axi_wr(5'h0c, 8'h00);
    host_acc(0, 1, 16'h2800, 8'h5a, 1, 19'h12800);
    host_acc(0, 0, 16'h6800, 8'h5a, 1, 19'h12800);
    host_acc(1, 1, 16'h2800, 8'ha5, 1, 19'h0a800);
    host_acc(1, 0, 16'h2800, 8'ha5, 1, 19'h0a800);
    host_acc(1, 0, 16'h4000, 8'h00, 0, 19'h0);
    host_acc(0, 0, 16'h8000, 8'h00, 0, 19'h0);
    axi_wr(5'h08, 8'h00);
    axi_wr(5'h10, 8'h83);
    host_acc(0, 1, 16'h4004, 8'h3c, 1, 19'h4c004);
    host_acc(0, 0, 16'h4004, 8'h3c, 1, 19'h4c004);
    axi_wr(5'h0c, 8'h80);
    host_acc(0, 0, 16'h4004, 8'h00, 0, 19'h0);
    axi_rd(5'h14, 8'h06, VWM_RESP_OKAY);
    give_verdict;
  end
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule : tb_top
